// ==== asrc_ctrl.sv ====
// Purpose: Host controller driving a 16-bit asynchronous static RAM.
// Assumes: 40 MHz clock; pins pass through one register stage.
// Notes: Request is taken in idle; one access at a time.
// Notes on behaviour
// - Write spans overlap of both selects, a lane select and write enable.
// - Write data stands setup time before write end, held after it.
// - Address stands address setup time before the write-ending edge.
// - Address valid at write start and kept until after write end.
// - Both selects asserted select-to-end time before write end.
// - Chosen lane select asserted lane time before write end.
// - Write enable low pulse width; longer when output enable low.
// - Host keeps output enable high during writes before driving data.
// - Address clean and steady for every read and write cycle.
// - In retention hold every input at a firm rail level; the controller leaves the data bus undriven.
// - Deselect before supply drop; stay deselected a read cycle after.
// - Host never drives the bus while the device reads with outputs on.
`timescale 1ns/1ps

module asrc_ctrl #(
  parameter int SPEED_BIN = asrc_pkg::BIN_55,
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Request port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lane_n,
  // Read answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Retention control
  input wire logic retain_req,
  output logic retain_active,
  // Device pins
  output logic chip_select_active_low,
  output logic chip_select_active_high,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i
);
  import asrc_pkg::*;

  // ****************************************************************
  // Cycle counts, rounded up to whole clocks
  // ****************************************************************
  localparam int B = SPEED_BIN;
  // Read: access time plus two synchroniser stages and the pin register
  localparam int RD_CYC =
    ns_to_cyc(SELECT_ACCESS_TIME_NS[B] > LANE_ACCESS_TIME_NS[B] ?
              SELECT_ACCESS_TIME_NS[B] : LANE_ACCESS_TIME_NS[B]) + 3;
  // Gap after deselect so the device has floated before any drive
  localparam int TURN_CYC = ns_to_cyc(
    DESELECT_RELEASE_DELAY_NS[B] > OUTPUT_DISABLE_RELEASE_DELAY_NS[B] ?
    DESELECT_RELEASE_DELAY_NS[B] :
    OUTPUT_DISABLE_RELEASE_DELAY_NS[B]);
  localparam int REL_CYC = ns_to_cyc(WRITE_START_RELEASE_DELAY_NS[B]);
  // Write pulse covers every setup to the write-ending edge
  localparam int PW_MAX1 =
    WRITE_PULSE_WIDTH_NS[B] > SELECT_TO_WRITE_END_NS[B] ?
    WRITE_PULSE_WIDTH_NS[B] : SELECT_TO_WRITE_END_NS[B];
  localparam int PW_MAX2 =
    ADDRESS_SETUP_TO_WRITE_END_NS[B] > LANE_SELECT_TO_WRITE_END_NS[B] ?
    ADDRESS_SETUP_TO_WRITE_END_NS[B] : LANE_SELECT_TO_WRITE_END_NS[B];
  localparam int PW_MAX3 = PW_MAX1 > PW_MAX2 ? PW_MAX1 : PW_MAX2;
  localparam int PW_NS = PW_MAX3 > DATA_SETUP_TO_WRITE_END_NS[B] ?
    PW_MAX3 : DATA_SETUP_TO_WRITE_END_NS[B];
  localparam int PW_CYC = ns_to_cyc(PW_NS);
  // Cycle time not already spent in the pulse, at least one hold cycle
  localparam int WC_REST = ns_to_cyc(WRITE_CYCLE_MIN_NS[B]) - PW_CYC;
  localparam int REC_CYC = WC_REST > 1 ? WC_REST : 1;
  localparam int RDR_CYC = ns_to_cyc(READ_CYCLE_MIN_NS[B]);

  localparam logic [CNT_W-1:0] RD_N = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_N = CNT_W'(TURN_CYC - 1);
  localparam logic [CNT_W-1:0] REL_N = CNT_W'(REL_CYC - 1);
  localparam logic [CNT_W-1:0] PW_N = CNT_W'(PW_CYC - 1);
  localparam logic [CNT_W-1:0] REC_N = CNT_W'(REC_CYC - 1);
  localparam logic [CNT_W-1:0] RDR_N = CNT_W'(RDR_CYC - 1);

  // Elaboration-time checks
  if (SPEED_BIN < BIN_35 || SPEED_BIN > BIN_55) begin : g_bad_bin
    $error("SPEED_BIN must be 0, 1 or 2");
  end
  if (DATA_W != 16 || ADDR_W < 1) begin : g_bad_width
    $error("Data width must be 16 and address width positive");
  end
  if (RD_CYC > (1 << CNT_W) || PW_CYC > (1 << CNT_W)) begin : g_bad_cnt
    $error("Cycle counts exceed the counter width");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  asrc_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [1:0] lane_n_q;
  logic [DATA_W-1:0] rdata_q;
  logic rsp_valid_q;
  logic cnt_done;
  logic take;

  asrc_pins_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) pins ();

  assign cnt_done = (cnt_q == '0);
  // Requests with no lane selected are not taken
  assign req_ready = (state_q == asrc_idle) && !retain_req &&
                     (req_lane_n != LANES_NONE);
  assign take = clk_en && req_valid && req_ready;

  // Sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= asrc_idle;
      cnt_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        asrc_idle: begin
          if (retain_req) begin
            state_q <= asrc_retain;
          end else if (req_valid && req_lane_n != LANES_NONE) begin
            if (req_write) begin
              state_q <= asrc_wr_release;
              cnt_q <= REL_N;
            end else begin
              state_q <= asrc_rd_access;
              cnt_q <= RD_N;
            end
          end
        end
        asrc_rd_access: begin
          if (cnt_done) begin
            state_q <= asrc_rd_turn;
            cnt_q <= TURN_N;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        asrc_rd_turn: begin
          // Device floats before anything may drive the bus
          if (cnt_done) begin
            state_q <= asrc_idle;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        asrc_wr_release: begin
          // Selected with write enable low, bus not yet driven
          if (cnt_done) begin
            state_q <= asrc_wr_pulse;
            cnt_q <= PW_N;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        asrc_wr_pulse: begin
          if (cnt_done) begin
            state_q <= asrc_wr_recover;
            cnt_q <= REC_N;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        asrc_wr_recover: begin
          if (cnt_done) begin
            state_q <= asrc_idle;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        asrc_retain: begin
          if (!retain_req) begin
            state_q <= asrc_resume;
            cnt_q <= RDR_N;
          end
        end
        asrc_resume: begin
          // Deselected one read cycle before next access
          if (cnt_done) begin
            state_q <= asrc_idle;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= asrc_idle;
        end
      endcase
    end
  end

  // Request capture; address and data stand for the whole access
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_q <= '0;
      wdata_q <= '0;
      lane_n_q <= LANES_NONE;
    end else if (take) begin
      addr_q <= req_addr;
      wdata_q <= req_wdata;
      lane_n_q <= req_lane_n;
    end
  end

  // Read data capture at the end of access, unselected lanes zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
      rsp_valid_q <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_q <= (state_q == asrc_rd_access) && cnt_done;
      if ((state_q == asrc_rd_access) && cnt_done) begin
        rdata_q[7:0] <= lane_n_q[0] ? 8'h00 : pins.rdata_sync[7:0];
        rdata_q[15:8] <= lane_n_q[1] ? 8'h00 : pins.rdata_sync[15:8];
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign retain_active = (state_q == asrc_retain);

  // Pin levels per state
  always_comb begin
    pins.chip_select_active_low = 1'b1;
    pins.chip_select_active_high = 1'b0;
    pins.write_enable_n = 1'b1;
    pins.output_enable_n = 1'b1;
    pins.upper_lane_select_n = 1'b1;
    pins.lower_lane_select_n = 1'b1;
    pins.addr = addr_q;
    pins.wdata = wdata_q;
    pins.data_oe = 1'b0;
    case (state_q)
      asrc_rd_access: begin
        pins.chip_select_active_low = 1'b0;
        pins.chip_select_active_high = 1'b1;
        pins.output_enable_n = 1'b0;
        pins.upper_lane_select_n = lane_n_q[1];
        pins.lower_lane_select_n = lane_n_q[0];
      end
      asrc_wr_release, asrc_wr_pulse: begin
        // All four write terms held; write ends on write enable rise
        pins.chip_select_active_low = 1'b0;
        pins.chip_select_active_high = 1'b1;
        pins.write_enable_n = 1'b0;
        pins.upper_lane_select_n = lane_n_q[1];
        pins.lower_lane_select_n = lane_n_q[0];
        pins.data_oe = (state_q == asrc_wr_pulse);
      end
      asrc_wr_recover: begin
        // Data and address held past the write-ending edge
        pins.data_oe = 1'b1;
      end
      asrc_retain: begin
        // Firm rail levels: deselected, lanes off, bus undriven
        pins.addr = '0;
      end
      default: begin
      end
    endcase
  end

  asrc_pin_stage #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_stage (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .pins(pins.stage),
    .chip_select_active_low(chip_select_active_low),
    .chip_select_active_high(chip_select_active_high),
    .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n),
    .upper_lane_select_n(upper_lane_select_n),
    .lower_lane_select_n(lower_lane_select_n),
    .addr(addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i)
  );

endmodule

// ==== asrc_pkg.sv ====
// Purpose: Shared constants for the asynchronous SRAM host controller.
// Assumes: Controller clock of 40 MHz; speed bin chosen by parameter.
// Notes: Times are in ns as printed; cycle counts derive from them.
package asrc_pkg;

  // ****************************************************************
  // Clock and speed bins
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIN_35 = 0;
  localparam int BIN_45 = 1;
  localparam int BIN_55 = 2;

  // ****************************************************************
  // Device timing per bin, in ns
  // ****************************************************************
  localparam int READ_CYCLE_MIN_NS [3] = '{35, 45, 55};
  localparam int SELECT_ACCESS_TIME_NS [3] = '{35, 45, 55};
  localparam int LANE_ACCESS_TIME_NS [3] = '{35, 45, 55};
  localparam int WRITE_CYCLE_MIN_NS [3] = '{35, 45, 55};
  localparam int SELECT_TO_WRITE_END_NS [3] = '{30, 35, 40};
  localparam int ADDRESS_SETUP_TO_WRITE_END_NS [3] = '{30, 35, 40};
  localparam int LANE_SELECT_TO_WRITE_END_NS [3] = '{30, 35, 40};
  localparam int WRITE_PULSE_WIDTH_NS [3] = '{30, 35, 40};
  localparam int DATA_SETUP_TO_WRITE_END_NS [3] = '{18, 20, 25};
  localparam int DATA_HOLD_AFTER_WRITE_END_NS = 0;
  localparam int ADDRESS_HOLD_AFTER_WRITE_END_NS = 0;
  localparam int ADDRESS_SETUP_TO_WRITE_START_NS = 0;
  localparam int WRITE_START_RELEASE_DELAY_NS [3] = '{12, 15, 20};
  localparam int OUTPUT_DISABLE_RELEASE_DELAY_NS [3] = '{12, 15, 20};
  localparam int DESELECT_RELEASE_DELAY_NS [3] = '{12, 15, 20};

  // Least times round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ****************************************************************
  // Controller sequencing
  // ****************************************************************
  localparam int CNT_W = 4;
  localparam logic [1:0] LANES_NONE = 2'h3;

  typedef enum logic [2:0] {
    asrc_idle,
    asrc_rd_access,
    asrc_rd_turn,
    asrc_wr_release,
    asrc_wr_pulse,
    asrc_wr_recover,
    asrc_retain,
    asrc_resume
  } asrc_state_e;

endpackage

// ==== asrc_pins_if.sv ====
// Purpose: Pin group between the controller core and its pin stage.
// Assumes: One clock; all signals registered in the pin stage.
// Notes: Select and enable levels here are as on the device pins.
`timescale 1ns/1ps

interface asrc_pins_if #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
);
  logic chip_select_active_low;
  logic chip_select_active_high;
  logic write_enable_n;
  logic output_enable_n;
  logic upper_lane_select_n;
  logic lower_lane_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic data_oe;
  logic [DATA_W-1:0] rdata_sync;

  modport core (
    output chip_select_active_low, chip_select_active_high,
    output write_enable_n, output_enable_n,
    output upper_lane_select_n, lower_lane_select_n,
    output addr, wdata, data_oe,
    input rdata_sync
  );
  modport stage (
    input chip_select_active_low, chip_select_active_high,
    input write_enable_n, output_enable_n,
    input upper_lane_select_n, lower_lane_select_n,
    input addr, wdata, data_oe,
    output rdata_sync
  );
endinterface

// ==== asrc_pin_stage.sv ====
// Purpose: Registers every pin output and synchronises the data input.
// Assumes: The data bus arrives from outside the clock domain.
// Notes: Deselected, write-idle levels come out of reset.
`timescale 1ns/1ps

module asrc_pin_stage #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Core side
  asrc_pins_if.stage pins,
  // Device pins
  output logic chip_select_active_low,
  output logic chip_select_active_high,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i
);
  import asrc_pkg::*;

  logic [DATA_W-1:0] dq_meta_q;
  logic [DATA_W-1:0] dq_sync_q;

  // Output pin flops
  always_ff @(posedge clk) begin
    if (reset) begin
      chip_select_active_low <= 1'b1;
      chip_select_active_high <= 1'b0;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      addr <= '0;
      dq_o <= '0;
      dq_oe <= 1'b0;
    end else if (clk_en) begin
      chip_select_active_low <= pins.chip_select_active_low;
      chip_select_active_high <= pins.chip_select_active_high;
      write_enable_n <= pins.write_enable_n;
      output_enable_n <= pins.output_enable_n;
      upper_lane_select_n <= pins.upper_lane_select_n;
      lower_lane_select_n <= pins.lower_lane_select_n;
      addr <= pins.addr;
      dq_o <= pins.wdata;
      dq_oe <= pins.data_oe;
    end
  end

  // Two-flop synchroniser on the data input
  always_ff @(posedge clk) begin
    if (reset) begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end else if (clk_en) begin
      dq_meta_q <= dq_i;
      dq_sync_q <= dq_meta_q;
    end
  end

  assign pins.rdata_sync = dq_sync_q;

endmodule

// ==== asrc_properties.sv ====
// Purpose: Pin timing checks for the SRAM host controller.
// Assumes: Counts are those of the 55 ns bin at 40 MHz.
// Notes: Bound to the top module from the bench.
`timescale 1ns/1ps

module asrc_properties #(
  parameter int SPEED_BIN = 2,
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host side
  input wire logic rsp_valid,
  input wire logic retain_req,
  input wire logic retain_active,
  // Device pins
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_write_gate;
    !write_enable_n |-> !chip_select_active_low && chip_select_active_high
      && !(upper_lane_select_n && lower_lane_select_n);
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("write enable low outside a selected lane");
  property p_write_pulse;
    $fell(write_enable_n) |=> !write_enable_n[*2] ##1 write_enable_n;
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("write pulse not three cycles");
  property p_data_setup;
    $rose(write_enable_n) |-> dq_oe && $past(dq_oe) && $stable(dq_o);
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("write data not settled at write end");
  property p_data_hold;
    $rose(write_enable_n) |=> !dq_oe;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data bus not released after hold");
  property p_addr_steady;
    !write_enable_n |=> $stable(addr);
  endproperty
  a_addr_steady: assert property (p_addr_steady)
    else $error("address moved during write");
  property p_release_first;
    $fell(write_enable_n) |-> !dq_oe ##1 dq_oe;
  endproperty
  a_release_first: assert property (p_release_first)
    else $error("bus driven without release cycle");
  property p_no_clash;
    dq_oe |-> output_enable_n;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("bus driven while outputs enabled");
  property p_read_window;
    $fell(output_enable_n) |-> (!output_enable_n && !rsp_valid)[*5] ##1
      (!output_enable_n && rsp_valid) ##1 output_enable_n;
  endproperty
  a_read_window: assert property (p_read_window)
    else $error("read window or answer out of place");
  property p_read_addr;
    !output_enable_n[*2] |-> $stable(addr);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("address moved during read");
  property p_turn;
    rsp_valid |=> chip_select_active_low ##1 chip_select_active_low;
  endproperty
  a_turn: assert property (p_turn)
    else $error("no deselected turn after read");
  property p_retain_pins;
    retain_active[*2] |-> chip_select_active_low && !chip_select_active_high
      && upper_lane_select_n && lower_lane_select_n && addr == '0;
  endproperty
  a_retain_pins: assert property (p_retain_pins)
    else $error("pins not at rest in retention");
  property p_recover;
    $fell(retain_req) && retain_active |-> chip_select_active_low[*3];
  endproperty
  a_recover: assert property (p_recover)
    else $error("access too soon after retention");
  c_read: cover property ($rose(rsp_valid));
  c_write: cover property ($rose(write_enable_n));
  c_retain: cover property ($rose(retain_active));
endmodule

// ==== asrc_sram_model.sv ====
// Purpose: Behavioural 16-bit static RAM for the host controller bench.
// Assumes: 55 ns part; host errors are counted, not stopped.
// Notes: Undriven bus shows a pattern that changes every 11 ns.
`timescale 1ns/1ps

module asrc_sram_model (
  // Control pins
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic [17:0] addr,
  // Data bus
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  // Bench control and host fault count
  input wire logic slow,
  output int host_err
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] junk = 16'hA5C3;
  logic [15:0] wd;
  logic [17:0] wa;
  logic [1:0] wl = 2'h3;
  logic [1:0] want, late, drv;
  logic sel, wr_on;
  time t_dat, t_adr, t_wef;

  // ****************************************************************
  // Device behaviour
  // ****************************************************************
  initial host_err = 0;
  assign sel = !chip_select_active_low && chip_select_active_high;
  assign wr_on = sel && !write_enable_n
    && !(upper_lane_select_n && lower_lane_select_n);
  // Lanes that read mode with outputs on may drive
  assign want = {2{sel && write_enable_n && !output_enable_n}}
    & ~{upper_lane_select_n, lower_lane_select_n};
  // Drivers turn on late, promptly or slowly, and off at once
  always @(want) late <= #(slow ? 50 : 12) want;
  assign drv = want & late;
  always #11 junk = {junk[0], junk[15:1]} ^ 16'h1234;
  // Bus level from both parties
  always @* begin
    dq_i = junk;
    if (drv[0]) dq_i[7:0] = mem[addr][7:0];
    if (drv[1]) dq_i[15:8] = mem[addr][15:8];
    if (dq_oe) dq_i = dq_o;
  end
  // Time stamps for host setup checks
  always @(dq_o or dq_oe) t_dat = $time;
  always @(addr) t_adr = $time;
  always @(negedge write_enable_n) t_wef = $time;
  always @(negedge write_enable_n) #5 begin
    wl = {upper_lane_select_n, lower_lane_select_n};
    wa = addr;
  end
  always @(dq_i or dq_oe) if (wr_on && dq_oe) wd = dq_i;
  // Store at write end and judge the host's timing
  always @(negedge wr_on) begin
    if (wl != 2'h3 && ($time - t_dat < 25 || $time - t_adr < 40
        || $time - t_wef < 40)) host_err++;
    if (!wl[0]) mem[wa][7:0] = wd[7:0];
    if (!wl[1]) mem[wa][15:8] = wd[15:8];
  end
  // Host must not drive while outputs are on
  always @* if (dq_oe && |want) host_err++;
endmodule

// ==== asrc_testbench.sv ====
// Purpose: Self-checking bench for the SRAM host controller.
// Assumes: 55 ns bin; device model on the pins.
// Notes: Reads are checked against a queue of expected words.
`timescale 1ns/1ps

bind asrc_ctrl asrc_properties #(.SPEED_BIN(SPEED_BIN), .ADDR_W(ADDR_W),
  .DATA_W(DATA_W)) u_asrc_properties (.clk, .reset, .rsp_valid,
  .retain_req, .retain_active, .chip_select_active_low,
  .chip_select_active_high, .write_enable_n, .output_enable_n,
  .upper_lane_select_n, .lower_lane_select_n, .addr, .dq_o, .dq_oe);

module testbench;
  logic clk, req_ready, rsp_valid, retain_active, dq_oe;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic retain_req = 1'b0;
  logic slow = 1'b0;
  logic [17:0] req_addr = 18'h0;
  logic [17:0] addr;
  logic [15:0] req_wdata = 16'h0;
  logic [15:0] rsp_rdata, dq_o, dq_i, r;
  logic [1:0] req_lane_n = 2'h0;
  logic chip_select_active_low, chip_select_active_high;
  logic write_enable_n, output_enable_n;
  logic upper_lane_select_n, lower_lane_select_n;
  int bad_count = 0;
  int samples_checked = 0;
  int host_err, n;
  logic [31:0] seed = 32'h75F7DC8C;
  logic [15:0] ref_mem [16];
  logic [15:0] exp_q [$];

  asrc_ctrl #(.SPEED_BIN(2)) u_asrc_ctrl (.clk, .reset, .clk_en,
    .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .req_lane_n,
    .rsp_valid, .rsp_rdata, .retain_req, .retain_active,
    .chip_select_active_low, .chip_select_active_high, .write_enable_n,
    .output_enable_n, .upper_lane_select_n, .lower_lane_select_n, .addr,
    .dq_o, .dq_oe, .dq_i);
  asrc_sram_model u_asrc_sram_model (.chip_select_active_low,
    .chip_select_active_high, .write_enable_n, .output_enable_n,
    .upper_lane_select_n, .lower_lane_select_n, .addr, .dq_o, .dq_oe,
    .dq_i, .slow, .host_err);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  function automatic logic [15:0] pins();
    return {9'h0, chip_select_active_low, chip_select_active_high,
      write_enable_n, output_enable_n, upper_lane_select_n,
      lower_lane_select_n, dq_oe};
  endfunction

  task automatic check(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One access; held until taken, then the expectation is noted
  task automatic access(input logic wr, input logic [3:0] k,
      input logic [1:0] ln, input logic [15:0] d);
    int w;
    @(posedge clk);
    #2;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = {k, 10'h2A5, k};
    req_wdata = d;
    req_lane_n = ln;
    w = 0;
    while (req_ready !== 1'b1 && w < 100) begin
      @(posedge clk);
      #2;
      w++;
    end
    check({15'h0, req_ready}, 16'h0001, "request not taken");
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    if (wr) begin
      if (!ln[0]) ref_mem[k][7:0] = d[7:0];
      if (!ln[1]) ref_mem[k][15:8] = d[15:8];
    end else begin
      exp_q.push_back({ln[1] ? 8'h00 : ref_mem[k][15:8],
        ln[0] ? 8'h00 : ref_mem[k][7:0]});
    end
  endtask

  // Read answers are compared with the oldest note
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() > 0) check(rsp_rdata, exp_q.pop_front(), "read");
      else check(16'h0001, 16'h0000, "answer without read");
    end
  end

  // Cut a hang short
  initial begin
    #(25 * 12000);
    bad_count++;
    conclude();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    #2;
    reset = 1'b0;
    @(posedge clk);
    #2;
    check(pins(), 16'h005E, "idle pins");
    done("reset");
    for (int k = 0; k < 16; k++) access(1'b1, k[3:0], 2'h0, rnd());
    for (int k = 0; k < 48; k++) begin
      access(1'b1, k[3:0], 2'(k % 3), rnd());
      access(1'b0, k[3:0], 2'((k + 1) % 3), 16'h0);
    end
    done("lanes");
    // Let the last read finish so the pins are back at rest
    repeat (10) @(posedge clk);
    #2;
    req_valid = 1'b1;
    req_lane_n = 2'h3;
    repeat (4) begin
      @(posedge clk);
      #2;
      check({15'h0, req_ready}, 16'h0000, "refused ready");
      check(pins(), 16'h005E, "refused pins");
    end
    req_valid = 1'b0;
    req_lane_n = 2'h0;
    done("refusal");
    slow = 1'b1;
    for (int k = 0; k < 16; k++) access(1'b0, k[3:0], 2'h0, 16'h0);
    slow = 1'b0;
    done("slow device");
    @(posedge clk);
    #2;
    retain_req = 1'b1;
    repeat (10) @(posedge clk);
    #2;
    check({15'h0, retain_active}, 16'h0001, "retain state");
    check(pins(), 16'h005E, "retain pins");
    check(addr[15:0], 16'h0000, "retain address");
    retain_req = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #2;
      n++;
    end
    check({15'h0, n >= 3}, 16'h0001, "recovery wait");
    for (int k = 0; k < 4; k++) access(1'b0, k[3:0], 2'h0, 16'h0);
    done("retention");
    for (int k = 0; k < 80; k++) begin
      r = rnd();
      access(r[0], r[7:4], (r[9:8] == 2'h3) ? 2'h0 : r[9:8], rnd());
    end
    done("random");
    n = 0;
    while (exp_q.size() > 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check(16'(exp_q.size()), 16'h0000, "reads unanswered");
    check(host_err[15:0], 16'h0000, "host timing");
    conclude();
  end
endmodule
